// ### common/tmtwo_cfg.svh
// Constants for the timer two capture/reload block
`ifndef TMTWO_CFG_SVH
`define TMTWO_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TMTWO_ADDR_W        8
`define TMTWO_OFS_CTRL      8'hc8
`define TMTWO_OFS_RCL       8'hca
`define TMTWO_OFS_RCH       8'hcb
`define TMTWO_OFS_CNTL      8'hcc
`define TMTWO_OFS_CNTH      8'hcd
`define TMTWO_OFS_AUX       8'hce

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TMTWO_BIT_OVF       7
`define TMTWO_BIT_EXF       6
`define TMTWO_BIT_RXSEL     5
`define TMTWO_BIT_TXSEL     4
`define TMTWO_BIT_TRIGEN    3
`define TMTWO_BIT_RUN       2
`define TMTWO_BIT_CTSEL     1
`define TMTWO_BIT_CAPSEL    0

// Auxiliary register fields
`define TMTWO_BIT_OUTEN     0
`define TMTWO_BIT_IRQEN     1
`define TMTWO_BIT_GIE       2

// ----------------------------------------------------------------
// Reset values and counter constants
// ----------------------------------------------------------------
`define TMTWO_RST_BYTE      8'h00
`define TMTWO_RST_WORD      16'h0000
`define TMTWO_CNT_ONES      16'hffff
`define TMTWO_CNT_ONE       16'h0001

`endif

// ### common/tmtwo_pkg.sv
// Types for the timer two capture/reload block
package tmtwo_pkg;

    typedef struct packed {
        logic       ovf;
        logic       exf;
        logic       rx_sel;
        logic       tx_sel;
        logic       trig_en;
        logic       run;
        logic       ct_sel;
        logic       cap_sel;
    } tmtwo_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmtwo_bus_t;

    typedef enum logic {
        TMTWO_PH_A,
        TMTWO_PH_B
    } tmtwo_phase_t;

endpackage

// ### hdl/tmtwo_timer.sv
// Timer two: 16-bit counter with auto-reload, capture and baud output
//
// Notes on behaviour
// - Overflow flag sets on every wrap unless a serial clock select is 1.
// - Edge flag sets when a trigger edge causes capture or reload.
// - Receive select 1 routes this overflow as the serial receive clock.
// - Transmit select 1 routes this overflow as the serial transmit clock.
// - Trigger edges act only with trigger enable 1 and both selects 0.
// - The count advances only while run control is 1.
// - In timer mode the count steps once every two system clocks.
// - In counter mode the count steps on each count pin falling edge.
// - Reload mode reloads on overflow and on enabled trigger edges.
// - Capture mode captures on enabled trigger edges, no overflow reload.
// - Any serial select forces auto-reload on overflow.
// - The reload/capture pair is read/write and resets to zero.
// - The count pair is read/write and resets to zero.
// - With output enable set, a pin toggles on each overflow.
// - The interrupt asks only with its enable and global enable set.
`include "tmtwo_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module tmtwo_timer (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output var  logic [7:0] rdata,
    input  wire logic       count_input_pin,
    input  wire logic       trigger_pin,
    input  wire logic       t1_ovf,
    output var  logic       uart_rx_clk,
    output var  logic       uart_tx_clk,
    output var  logic       ovf_out,
    output var  logic       ovf_out_oe_n,
    output var  logic       irq
);

    // ------------------------------------------------------------
    // Bus capture
    // ------------------------------------------------------------
    tmtwo_pkg::tmtwo_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [1:0] cnt_sync_r;
    logic [1:0] cnt_sync_nxt;
    logic [1:0] trg_sync_r;
    logic [1:0] trg_sync_nxt;
    logic       cnt_prev_r;
    logic       trg_prev_r;
    logic       cnt_fall;
    logic       trg_fall;

    always_comb begin
        cnt_sync_nxt = {cnt_sync_r[0], count_input_pin};
        trg_sync_nxt = {trg_sync_r[0], trigger_pin};
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_sync_r <= 2'h3;
            trg_sync_r <= 2'h3;
            cnt_prev_r <= 1'b1;
            trg_prev_r <= 1'b1;
        end else begin
            cnt_sync_r <= cnt_sync_nxt;
            trg_sync_r <= trg_sync_nxt;
            cnt_prev_r <= cnt_sync_r[1];
            trg_prev_r <= trg_sync_r[1];
        end
    end

    assign cnt_fall = cnt_prev_r & ~cnt_sync_r[1];
    assign trg_fall = trg_prev_r & ~trg_sync_r[1];

    // ------------------------------------------------------------
    // Counter, flags and registers
    // ------------------------------------------------------------
    tmtwo_pkg::tmtwo_ctrl_t  ctrl_r;
    tmtwo_pkg::tmtwo_ctrl_t  ctrl_nxt;
    tmtwo_pkg::tmtwo_phase_t phase_r;
    tmtwo_pkg::tmtwo_phase_t phase_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] rcap_r;
    logic [15:0] rcap_nxt;
    logic [2:0]  aux_r;
    logic [2:0]  aux_nxt;
    logic        ovf_tgl_r;
    logic        ovf_tgl_nxt;
    logic        ovf_pulse_r;
    logic        ovf_pulse_nxt;
    logic        step;
    logic        wrap;
    logic        baud;
    logic        trig_act;

    assign baud     = ctrl_r.rx_sel | ctrl_r.tx_sel;
    assign trig_act = trg_fall & ctrl_r.trig_en & ~baud;
    assign step     = ctrl_r.run & (ctrl_r.ct_sel ? cnt_fall
                      : (phase_r == tmtwo_pkg::TMTWO_PH_B));
    assign wrap     = step & (cnt_r == `TMTWO_CNT_ONES);

    always_comb begin
        ctrl_nxt      = ctrl_r;
        cnt_nxt       = cnt_r;
        rcap_nxt      = rcap_r;
        aux_nxt       = aux_r;
        ovf_tgl_nxt   = ovf_tgl_r;
        ovf_pulse_nxt = wrap;
        phase_nxt     = phase_r;
        if (ctrl_r.run && !ctrl_r.ct_sel) begin
            phase_nxt = (phase_r == tmtwo_pkg::TMTWO_PH_A)
                      ? tmtwo_pkg::TMTWO_PH_B
                      : tmtwo_pkg::TMTWO_PH_A;
        end
        // Software writes first so hardware events below win
        if (bus.wr) begin
            unique case (bus.addr)
                `TMTWO_OFS_CTRL: ctrl_nxt = bus.wdata;
                `TMTWO_OFS_RCL:  rcap_nxt[7:0] = bus.wdata;
                `TMTWO_OFS_RCH:  rcap_nxt[15:8] = bus.wdata;
                `TMTWO_OFS_CNTL: cnt_nxt[7:0] = bus.wdata;
                `TMTWO_OFS_CNTH: cnt_nxt[15:8] = bus.wdata;
                `TMTWO_OFS_AUX:  aux_nxt = bus.wdata[2:0];
                default: ;
            endcase
        end
        if (step) begin
            cnt_nxt = 16'(cnt_r + `TMTWO_CNT_ONE);
        end
        if (wrap) begin
            ovf_tgl_nxt = ~ovf_tgl_r;
            if (!baud) begin
                ctrl_nxt.ovf = 1'b1;
            end
            if (baud || !ctrl_r.cap_sel) begin
                cnt_nxt = rcap_r;
            end
        end
        if (trig_act) begin
            ctrl_nxt.exf = 1'b1;
            if (ctrl_r.cap_sel) begin
                rcap_nxt = cnt_r;
            end else begin
                cnt_nxt = rcap_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r      <= `TMTWO_RST_BYTE;
            cnt_r       <= `TMTWO_RST_WORD;
            rcap_r      <= `TMTWO_RST_WORD;
            aux_r       <= 3'h0;
            ovf_tgl_r   <= 1'b0;
            ovf_pulse_r <= 1'b0;
            phase_r     <= tmtwo_pkg::TMTWO_PH_A;
        end else begin
            ctrl_r      <= ctrl_nxt;
            cnt_r       <= cnt_nxt;
            rcap_r      <= rcap_nxt;
            aux_r       <= aux_nxt;
            ovf_tgl_r   <= ovf_tgl_nxt;
            ovf_pulse_r <= ovf_pulse_nxt;
            phase_r     <= phase_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read port and outputs
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;
    logic       rxc_nxt;
    logic       txc_nxt;
    logic       irq_nxt;

    always_comb begin
        rdata_nxt = `TMTWO_RST_BYTE;
        if (bus.rd) begin
            unique case (bus.addr)
                `TMTWO_OFS_CTRL: rdata_nxt = ctrl_r;
                `TMTWO_OFS_RCL:  rdata_nxt = rcap_r[7:0];
                `TMTWO_OFS_RCH:  rdata_nxt = rcap_r[15:8];
                `TMTWO_OFS_CNTL: rdata_nxt = cnt_r[7:0];
                `TMTWO_OFS_CNTH: rdata_nxt = cnt_r[15:8];
                `TMTWO_OFS_AUX:  rdata_nxt = {5'h00, aux_r};
                default:         rdata_nxt = `TMTWO_RST_BYTE;
            endcase
        end
        rxc_nxt = ctrl_nxt.rx_sel ? ovf_pulse_nxt : t1_ovf;
        txc_nxt = ctrl_nxt.tx_sel ? ovf_pulse_nxt : t1_ovf;
        irq_nxt = aux_nxt[`TMTWO_BIT_IRQEN] & aux_nxt[`TMTWO_BIT_GIE]
                  & (ctrl_nxt.ovf | ctrl_nxt.exf);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata        <= `TMTWO_RST_BYTE;
            uart_rx_clk  <= 1'b0;
            uart_tx_clk  <= 1'b0;
            ovf_out      <= 1'b0;
            ovf_out_oe_n <= 1'b1;
            irq          <= 1'b0;
        end else begin
            rdata        <= rdata_nxt;
            uart_rx_clk  <= rxc_nxt;
            uart_tx_clk  <= txc_nxt;
            ovf_out      <= ovf_tgl_nxt;
            ovf_out_oe_n <= ~aux_nxt[`TMTWO_BIT_OUTEN];
            irq          <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ovf_flag_set: assert property (wrap && !baud |=> ctrl_r.ovf)
        else $error("overflow flag not set on wrap");
    a_edge_flag_set: assert property (trig_act |=> ctrl_r.exf)
        else $error("edge flag not set on trigger");
    a_rx_clk_route: assert property (ctrl_r.rx_sel && wrap
                                     |=> uart_rx_clk)
        else $error("receive clock missing overflow");
    a_tx_clk_route: assert property (!ctrl_r.tx_sel && $past(t1_ovf)
                                     && !$past(wr) |-> uart_tx_clk)
        else $error("transmit clock not from timer one");
    a_trig_blocked: assert property (baud && !wr |=>
                                     $stable(rcap_r))
        else $error("trigger acted in baud mode");
    a_run_hold: assert property (!ctrl_r.run && !wr && !trig_act
                                 |=> $stable(cnt_r))
        else $error("count moved while stopped");
    a_timer_rate: assert property (ctrl_r.run && !ctrl_r.ct_sel && step
                                   |=> !step)
        else $error("timer stepped twice in a row");
    a_cnt_edge: assert property (ctrl_r.run && ctrl_r.ct_sel
                                 && !step && !wr && !trig_act
                                 |=> $stable(cnt_r))
        else $error("counter moved without edge");
    a_reload_wrap: assert property (wrap && (baud || !ctrl_r.cap_sel)
                                    && !trig_act
                                    |=> cnt_r == $past(rcap_r))
        else $error("no reload on overflow");
    a_capture_val: assert property (trig_act && ctrl_r.cap_sel
                                    |=> rcap_r == $past(cnt_r))
        else $error("capture value wrong");
    a_irq_gate: assert property (irq |-> aux_r[`TMTWO_BIT_IRQEN]
                                 && aux_r[`TMTWO_BIT_GIE])
        else $error("interrupt without enables");

    // ------------------------------------------------------------
    // Flag, routing, mode and register checks
    // ------------------------------------------------------------
    a_ovf_baud_quiet: assert property (wrap && baud && !wr && !ctrl_r.ovf
                                       |=> !ctrl_r.ovf)
        else $error("overflow flag set in baud mode");
    a_ovf_flag_hold: assert property (ctrl_r.ovf && !wr
                                      |=> ctrl_r.ovf)
        else $error("overflow flag lost without write");
    a_edge_flag_hold: assert property (ctrl_r.exf && !wr
                                       |=> ctrl_r.exf)
        else $error("edge flag lost without write");
    a_edge_needs_trig: assert property (!trig_act && !wr && !ctrl_r.exf
                                        |=> !ctrl_r.exf)
        else $error("edge flag set without trigger");
    a_rx_from_t1: assert property (!ctrl_r.rx_sel && $past(t1_ovf)
                                   |-> uart_rx_clk)
        else $error("receive clock not from timer one");
    a_tx_from_timer: assert property (ctrl_r.tx_sel && wrap && !wr
                                      |=> uart_tx_clk)
        else $error("transmit clock missing overflow");
    a_baud_no_trig: assert property (baud && !wr && !step
                                     |=> $stable(cnt_r))
        else $error("trigger reloaded in baud mode");
    a_run_step: assert property (!ctrl_r.run |-> !step)
        else $error("step while stopped");
    a_timer_step: assert property (ctrl_r.run && !ctrl_r.ct_sel && !step
                                   && !wr |=> step)
        else $error("timer missed its step");
    a_cnt_edge_step: assert property (ctrl_r.run && ctrl_r.ct_sel
                                      && cnt_fall |-> step)
        else $error("counter missed an edge");
    a_trig_reload: assert property (trig_act && !ctrl_r.cap_sel
                                    |=> cnt_r == $past(rcap_r))
        else $error("no reload on trigger");
    a_capture_wrap: assert property (wrap && ctrl_r.cap_sel && !baud
                                     && !trig_act && !wr
                                     |=> cnt_r == '0)
        else $error("capture mode reloaded on overflow");
    a_baud_reload: assert property (wrap && baud
                                    |=> cnt_r == $past(rcap_r))
        else $error("baud mode missed reload");
    a_rcl_write: assert property (wr && addr == `TMTWO_OFS_RCL && !trig_act
                                  |=> rcap_r[7:0] == $past(wdata))
        else $error("reload low byte write lost");
    a_rch_write: assert property (wr && addr == `TMTWO_OFS_RCH && !trig_act
                                  |=> rcap_r[15:8] == $past(wdata))
        else $error("reload high byte write lost");
    a_cntl_write: assert property (wr && addr == `TMTWO_OFS_CNTL && !step
                                   && !trig_act
                                   |=> cnt_r[7:0] == $past(wdata))
        else $error("count low byte write lost");
    a_cnth_write: assert property (wr && addr == `TMTWO_OFS_CNTH && !step
                                   && !trig_act
                                   |=> cnt_r[15:8] == $past(wdata))
        else $error("count high byte write lost");
    a_oe_level: assert property (ovf_out_oe_n
                                 == !aux_r[`TMTWO_BIT_OUTEN])
        else $error("output enable does not follow bit");
    a_ovf_toggle: assert property (wrap
                                   |=> ovf_out != $past(ovf_out))
        else $error("overflow output did not toggle");
    a_ovf_steady: assert property (!wrap |=> $stable(ovf_out))
        else $error("overflow output moved without wrap");
    a_irq_level: assert property (aux_r[`TMTWO_BIT_IRQEN]
                                  && aux_r[`TMTWO_BIT_GIE]
                                  && ctrl_r.ovf |-> irq)
        else $error("interrupt missing with flag set");
    a_trg_detect: assert property ($fell(trg_sync_r[1])
                                   |-> trg_fall)
        else $error("trigger edge not detected");
    a_cnt_detect: assert property ($fell(cnt_sync_r[1])
                                   |-> cnt_fall)
        else $error("count edge not detected");
    a_sync_depth: assert property ($fell(trg_sync_r[1])
                                   |-> $past(trigger_pin, 2) == 1'b0)
        else $error("trigger synchroniser depth wrong");

    c_wrap_reload: cover property (wrap && !ctrl_r.cap_sel);
    c_capture: cover property (trig_act && ctrl_r.cap_sel);
    c_baud_wrap: cover property (wrap && baud);
    c_count_mode: cover property (step && ctrl_r.ct_sel);
    c_trig_reload: cover property (trig_act && !ctrl_r.cap_sel);

endmodule

`default_nettype wire

// ### testbench/tmtwo_pins_model.sv
// Far-side model: count pin, trigger pin and Timer1 overflow source
`timescale 1ns/100ps
`default_nettype none

module tmtwo_pins_model (
    input  wire logic clk,
    output var  logic count_input_pin,
    output var  logic trigger_pin,
    output var  logic t1_ovf
);
    // Port pins idle high, as with their pull-ups
    initial begin
        count_input_pin = 1'b1;
        trigger_pin     = 1'b1;
        t1_ovf          = 1'b0;
    end

    // Each level stands at least two clocks so the synchroniser sees it
    task automatic pin_fall(input bit trig, input int n);
        repeat (n) begin
            @(posedge clk);
            if (trig) trigger_pin <= 1'b0;
            else count_input_pin <= 1'b0;
            repeat (3) @(posedge clk);
            trigger_pin     <= 1'b1;
            count_input_pin <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic t1_burst(input int n);
        repeat (n) begin
            @(posedge clk);
            t1_ovf <= 1'b1;
            @(posedge clk);
            t1_ovf <= 1'b0;
            @(posedge clk);
        end
    endtask
endmodule

`default_nettype wire

// ### testbench/tb_timer2_capture_reload.sv
// Self-checking bench for the timer two capture/reload block
`timescale 1ns/100ps
`default_nettype none

module tb_timer2_capture_reload;
    logic        clk, rstn, wr, rd, rd_seen;
    logic [7:0]  addr, wdata, rdata, sel;
    logic        cnt_pin, trig_pin, t1_ovf, rx_clk, tx_clk;
    logic        ovf_out, oe_n, irq;
    logic [7:0]  exp_q[$];
    logic [7:0]  v[4];
    logic [15:0] r16;
    int          bad_count, samples_checked, cyc, rx_n, tx_n, n0, n1;

    tmtwo_timer dut (
        .clk             (clk),
        .rstn            (rstn),
        .addr            (addr),
        .wdata           (wdata),
        .wr              (wr),
        .rd              (rd),
        .rdata           (rdata),
        .count_input_pin (cnt_pin),
        .trigger_pin     (trig_pin),
        .t1_ovf          (t1_ovf),
        .uart_rx_clk     (rx_clk),
        .uart_tx_clk     (tx_clk),
        .ovf_out         (ovf_out),
        .ovf_out_oe_n    (oe_n),
        .irq             (irq)
    );

    tmtwo_pins_model pins (
        .clk             (clk),
        .count_input_pin (cnt_pin),
        .trigger_pin     (trig_pin),
        .t1_ovf          (t1_ovf)
    );

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        rd    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        wr   <= 1'b0;
        rd   <= 1'b1;
        exp_q.push_back(e);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask

    task automatic rd16(input logic [7:0] a, input logic [15:0] e);
        rd_reg(a, e[7:0]);
        rd_reg(a + 8'h01, e[15:8]);
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr_reg(a, d[7:0]);
        wr_reg(a + 8'h01, d[15:8]);
    endtask

    // Read data stand only in the cycle after the read strobe
    always @(posedge clk) begin
        if (rd_seen === 1'b1)
            chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
        rd_seen <= rd;
        if (rx_clk === 1'b1) rx_n++;
        if (tx_clk === 1'b1) tx_n++;
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        {rstn, wr, rd, rd_seen, addr, wdata} = '0;
        {bad_count, samples_checked, cyc, rx_n, tx_n} = '0;
        void'($urandom(32'hce7c));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        chk({oe_n, irq, ovf_out, tx_clk}, 16'h0008);
        for (int a = 'hc8; a <= 'hce; a++)
            rd_reg(8'(a), 8'h00);
        for (int i = 0; i < 4; i++) begin
            v[i] = 8'($urandom);
            wr_reg(8'hca + 8'(i), v[i]);
        end
        for (int i = 0; i < 4; i++)
            rd_reg(8'hca + 8'(i), v[i]);
        // Timer mode, exactly twenty running clocks
        wr16(8'hcc, 16'h0000);
        wr_reg(8'hc8, 8'h04);
        idle(19);
        wr_reg(8'hc8, 8'h00);
        idle(4);
        rd16(8'hcc, 16'h000a);
        // Overflow with reload, output pin and interrupt
        wr_reg(8'hce, 8'h07);
        wr16(8'hca, 16'hfff0);
        wr16(8'hcc, 16'hffff);
        wr_reg(8'hc8, 8'h04);
        idle(4);
        rd_reg(8'hc8, 8'h84);
        wr_reg(8'hc8, 8'h80);
        idle(2);
        rd16(8'hcc, 16'hfff2);
        idle(2);
        chk({oe_n, irq, ovf_out}, 16'h0003);
        wr_reg(8'hce, 8'h03);
        idle(2);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(8'hce, 8'h07);
        idle(2);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(8'hc8, 8'h00);
        idle(2);
        chk({15'h0000, irq}, 16'h0000);
        // Serial clock sources, capture bit set but overridden
        for (int i = 0; i < 2; i++) begin
            sel = (i == 0) ? 8'h15 : 8'h25;
            wr16(8'hca, 16'hfffc);
            wr16(8'hcc, 16'hfffc);
            n0 = tx_n;
            n1 = rx_n;
            wr_reg(8'hc8, sel);
            fork
                idle(39);
                pins.t1_burst(3);
            join
            wr_reg(8'hc8, sel & 8'hfb);
            idle(4);
            chk(16'(tx_n - n0), (i == 0) ? 16'h0005 : 16'h0003);
            chk(16'(rx_n - n1), (i == 0) ? 16'h0003 : 16'h0005);
            rd_reg(8'hc8, sel & 8'hfb);
            rd16(8'hcc, 16'hfffc);
        end
        // Trigger capture, then trigger reload
        r16 = 16'($urandom);
        wr16(8'hcc, r16);
        wr_reg(8'hc8, 8'h09);
        idle(1);
        pins.pin_fall(1'b1, 1);
        rd_reg(8'hc8, 8'h49);
        rd16(8'hca, r16);
        wr_reg(8'hc8, 8'h08);
        wr16(8'hca, 16'h0a5a);
        idle(1);
        pins.pin_fall(1'b1, 1);
        rd_reg(8'hc8, 8'h48);
        rd16(8'hcc, 16'h0a5a);
        // Trigger edges that must be ignored
        wr16(8'hcc, 16'h1111);
        for (int i = 0; i < 3; i++) begin
            sel = (i == 0) ? 8'h01 : ((i == 1) ? 8'h19 : 8'h29);
            wr_reg(8'hc8, sel);
            idle(1);
            pins.pin_fall(1'b1, 1);
            rd_reg(8'hc8, sel);
            rd16(8'hcc, 16'h1111);
            rd16(8'hca, 16'h0a5a);
        end
        // Counter mode on count pin falling edges
        wr16(8'hcc, 16'h0000);
        wr_reg(8'hc8, 8'h06);
        idle(1);
        n0 = $urandom_range(9, 3);
        pins.pin_fall(1'b0, n0);
        wr_reg(8'hc8, 8'h00);
        idle(2);
        rd16(8'hcc, 16'(n0));
        idle(4);
        summarize();
    end
endmodule

`default_nettype wire
